/* File: rtl/ierp_pkg.sv */
/*
 * Shared constants for the indirect extended RAM port: bus offsets, widths,
 * reset values and access states.
 * Assumes a single synchronous clock domain and a byte-wide host bus.
 */
// Contract
// - 256 byte RAM, pointer spans 00h to FFh
// - Host loads pointer at 10h; device holds it
// - Offset 13h reads/writes RAM at pointer
// - Burst off: pointer unchanged by window accesses
// - Burst advance only while enable bit is one
// - Burst: increment on strobe rise, 13h only
// - Pointer wraps from FFh to 00h
package ierp_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int PTR_W = 8;
	localparam int RAM_DEPTH = 256;

	localparam logic [ADDR_W-1:0] OFF_POINTER = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_WINDOW = 5'h13;

	localparam logic [PTR_W-1:0] PTR_STEP = 8'h01;
	localparam logic [DATA_W-1:0] DOUT_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} ierp_state_e;

endpackage : ierp_pkg

/* File: rtl/ierp_ram_if.sv */
/*
 * Carrier between the port controller and its backing RAM.
 * Assumes both ends run on the same clock and clock enable.
 */
`timescale 1ns/1ps
interface ierp_ram_if;
	logic wr_en;
	logic [ierp_pkg::PTR_W-1:0] wr_addr;
	logic [ierp_pkg::DATA_W-1:0] wr_data;
	logic [ierp_pkg::PTR_W-1:0] rd_addr;
	logic [ierp_pkg::DATA_W-1:0] rd_data;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		input rd_data
	);

	modport mem (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_addr,
		output rd_data
	);
endinterface : ierp_ram_if

/* File: rtl/ierp_ram.sv */
/*
 * 256 x 8 storage with one write port and a registered read port.
 * Assumes the owner holds clock enable low to freeze it; contents are never reset.
 */
`timescale 1ns/1ps
module ierp_ram (
	input wire logic clk,
	input wire logic clk_en,
	ierp_ram_if.mem ram
);

	logic [ierp_pkg::DATA_W-1:0] mem_r [ierp_pkg::RAM_DEPTH];
	logic [ierp_pkg::DATA_W-1:0] rd_data_r;

	// Battery-backed array: no reset, power-up contents undefined
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (ram.wr_en) begin
				mem_r[ram.wr_addr] <= ram.wr_data;
			end
			rd_data_r <= mem_r[ram.rd_addr];
		end
	end

	assign ram.rd_data = rd_data_r;

endmodule : ierp_ram

/* File: rtl/ierp_top.sv */
/*
 * Indirect extended RAM port: a pointer latch and a data window reached over
 * a byte-wide strobed bus, with optional burst auto-increment.
 * Assumes bus pins are synchronous to MCLK and stable for at least one cycle
 * per strobe phase; the burst enable bit comes from a control register
 * outside this block.
 * Pointer and array keep no reset value; only bus state and outputs reset.
 * Clock enable low freezes every register, the array included.
 */
`timescale 1ns/1ps
module ierp_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic CS_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic [ierp_pkg::ADDR_W-1:0] ADDR,
	input wire logic [ierp_pkg::DATA_W-1:0] DATA_IN,
	input wire logic BURST_INCREMENT_ENABLE,
	output logic [ierp_pkg::DATA_W-1:0] DATA_OUT,
	output logic DATA_OE,
	output logic ACCESS_BUSY
);

	// Carrier to the backing array
	ierp_ram_if ram_bus ();

	// Backing array, frozen with the rest by clock enable
	ierp_ram u_ram (
		.clk(MCLK),
		.clk_en(CLK_EN),
		.ram(ram_bus.mem)
	);

	// Bus decode; WE wins over OE when both are low
	wire chip_sel = ~CS_N;
	wire wr_req = chip_sel & ~WE_N;
	wire rd_req = chip_sel & ~OE_N & WE_N;

	// Offset match
	wire hit_ptr = (ADDR == ierp_pkg::OFF_POINTER);
	wire hit_win = (ADDR == ierp_pkg::OFF_WINDOW);
	wire hit_map = hit_ptr | hit_win;

	// Access tracking state
	ierp_pkg::ierp_state_e st_r;
	ierp_pkg::ierp_state_e st_nxt;

	// Running access: offset and write byte
	logic [ierp_pkg::ADDR_W-1:0] acc_addr_r;
	logic [ierp_pkg::ADDR_W-1:0] acc_addr_nxt;
	logic [ierp_pkg::DATA_W-1:0] wdata_r;
	logic [ierp_pkg::DATA_W-1:0] wdata_nxt;

	// Pointer latch
	logic [ierp_pkg::PTR_W-1:0] ptr_r;
	logic [ierp_pkg::PTR_W-1:0] ptr_nxt;

	// Read port and status
	logic [ierp_pkg::DATA_W-1:0] dout_r;
	logic [ierp_pkg::DATA_W-1:0] dout_nxt;
	logic doe_r;
	logic doe_nxt;
	logic busy_r;
	logic busy_nxt;

	// Access tracking: an access ends on the rising edge of its strobe or select
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ierp_pkg::ST_IDLE: begin
				if (wr_req) begin
					st_nxt = ierp_pkg::ST_WRITE;
				end else if (rd_req) begin
					st_nxt = ierp_pkg::ST_READ;
				end
			end
			ierp_pkg::ST_READ: begin
				// A write may take over a running read
				if (wr_req) begin
					st_nxt = ierp_pkg::ST_WRITE;
				end else if (!rd_req) begin
					st_nxt = ierp_pkg::ST_IDLE;
				end
			end
			ierp_pkg::ST_WRITE: begin
				// Only the write strobe or select ends a write
				if (!wr_req) begin
					st_nxt = ierp_pkg::ST_IDLE;
				end
			end
			default: begin
				// Unused encoding falls back to idle
				st_nxt = ierp_pkg::ST_IDLE;
			end
		endcase
	end

	wire in_read = (st_r == ierp_pkg::ST_READ);
	wire in_write = (st_r == ierp_pkg::ST_WRITE);
	wire start_acc = (st_r == ierp_pkg::ST_IDLE) & (rd_req | wr_req);

	// Strobe rise: the access that was running has just finished
	wire end_read = in_read & ~rd_req & ~wr_req;
	wire end_write = in_write & ~wr_req;
	wire end_acc = end_read | end_write;

	// Offset held for the running access
	wire acc_ptr = (acc_addr_r == ierp_pkg::OFF_POINTER);
	wire acc_win = (acc_addr_r == ierp_pkg::OFF_WINDOW);

	// Address of the running access is held from its first cycle
	assign acc_addr_nxt = (start_acc | (in_read & wr_req)) ? ADDR : acc_addr_r;

	// Write data follows the bus until the strobe rises
	assign wdata_nxt = wr_req ? DATA_IN : wdata_r;

	// Pointer load, burst advance and wrap
	wire load_ptr = end_write & acc_ptr;
	wire win_done = end_acc & acc_win;
	wire burst_on = BURST_INCREMENT_ENABLE;
	wire adv_ptr = win_done & burst_on;

	// Burst step wraps at the top of the array
	wire [ierp_pkg::PTR_W-1:0] ptr_inc = ptr_r + ierp_pkg::PTR_STEP;

	// A pointer load wins over a burst step
	always_comb begin
		ptr_nxt = ptr_r;
		if (load_ptr) begin
			ptr_nxt = wdata_r;
		end else if (adv_ptr) begin
			ptr_nxt = ptr_inc;
		end
	end

	// RAM write on strobe rise, at the pointer before any burst step
	assign ram_bus.wr_en = end_write & acc_win;
	assign ram_bus.wr_addr = ptr_r;
	assign ram_bus.wr_data = wdata_r;

	// Read port follows the pointer so the window byte is ready early
	assign ram_bus.rd_addr = ptr_r;

	// Read data path: pointer latch or window byte, driven only for mapped reads
	wire rd_of_ptr = rd_req & hit_ptr;
	wire rd_of_win = rd_req & hit_win;
	wire rd_mapped = rd_req & hit_map;

	// Unmapped reads and idle cycles keep the last byte on the outputs
	wire [ierp_pkg::DATA_W-1:0] ptr_or_hold = rd_of_ptr ? ptr_r : dout_r;

	assign dout_nxt = rd_of_win ? ram_bus.rd_data : ptr_or_hold;
	assign doe_nxt = rd_mapped;
	assign busy_nxt = (st_nxt != ierp_pkg::ST_IDLE);

	// Access state
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= ierp_pkg::ST_IDLE;
		end else if (CLK_EN) begin
			st_r <= st_nxt;
		end
	end

	// Offset of the running access
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			acc_addr_r <= ierp_pkg::ADDR_RST;
		end else if (CLK_EN) begin
			acc_addr_r <= acc_addr_nxt;
		end
	end

	// Read data byte
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			dout_r <= ierp_pkg::DOUT_RST;
		end else if (CLK_EN) begin
			dout_r <= dout_nxt;
		end
	end

	// Read drive enable
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			doe_r <= 1'h0;
		end else if (CLK_EN) begin
			doe_r <= doe_nxt;
		end
	end

	// Busy status
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_r <= 1'h0;
		end else if (CLK_EN) begin
			busy_r <= busy_nxt;
		end
	end

	// Pointer latch: no reset, like the battery-backed array
	always_ff @(posedge MCLK) begin
		if (CLK_EN) begin
			ptr_r <= ptr_nxt;
		end
	end

	// Write holding byte
	always_ff @(posedge MCLK) begin
		if (CLK_EN) begin
			wdata_r <= wdata_nxt;
		end
	end

	// Outputs come straight from their flops
	assign DATA_OUT = dout_r;
	assign DATA_OE = doe_r;
	assign ACCESS_BUSY = busy_r;

endmodule : ierp_top

/* File: verif/ierp_checker.sv */
/* Port assertions for ierp_top.
 * Assumes one clock domain; bound below. */
`timescale 1ns/1ps
module ierp_checker (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic CS_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic [ierp_pkg::ADDR_W-1:0] ADDR,
	input wire logic [ierp_pkg::DATA_W-1:0] DATA_IN,
	input wire logic BURST_INCREMENT_ENABLE,
	input wire logic [ierp_pkg::DATA_W-1:0] DATA_OUT,
	input wire logic DATA_OE,
	input wire logic ACCESS_BUSY
);
	wire rd = CLK_EN & !CS_N & !OE_N & WE_N;
	wire wr = CLK_EN & !CS_N & !WE_N;
	wire win = ADDR == ierp_pkg::OFF_WINDOW;
	wire map = win || ADDR == ierp_pkg::OFF_POINTER;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	oe_rise_a: assert property (rd & map & !ACCESS_BUSY |=> DATA_OE) else $error("oe");
	bad_off_a: assert property (rd & !map & !ACCESS_BUSY |=> !DATA_OE) else $error("off");
	oe_drop_a: assert property (DATA_OE & CLK_EN & !rd |=> !DATA_OE) else $error("drop");
	wr_busy_a: assert property (wr & map |=> ACCESS_BUSY) else $error("wbusy");
	rd_busy_a: assert property (rd & map |=> ACCESS_BUSY) else $error("rbusy");
	busy_end_a: assert property (CLK_EN & CS_N ##1 CLK_EN & CS_N |=> !ACCESS_BUSY)
		else $error("end");
	en_freeze_a: assert property (!CLK_EN |=> $stable(DATA_OUT) && $stable(DATA_OE))
		else $error("frz");
	out_hold_a: assert property (CLK_EN & CS_N & !DATA_OE |=> $stable(DATA_OUT))
		else $error("hold");
	win_hold_a: assert property (rd & win & DATA_OE ##1 rd & win |=> $stable(DATA_OUT))
		else $error("win");
	c_burst: cover property (rd && win && BURST_INCREMENT_ENABLE);
	c_wrap_load: cover property (wr && !win && map && DATA_IN == 8'hFC);
	c_wr_win: cover property (wr && win);
	c_freeze: cover property (!CLK_EN ##1 CLK_EN);
endmodule : ierp_checker
bind ierp_top ierp_checker chk (.MCLK, .RST_N, .CLK_EN, .CS_N, .OE_N, .WE_N, .ADDR,
	.DATA_IN, .BURST_INCREMENT_ENABLE, .DATA_OUT, .DATA_OE, .ACCESS_BUSY);

/* File: verif/ierp_host.sv */
/* Host model on the strobed byte bus.
 * Assumes MCLK is also the bus clock. */
`timescale 1ns/1ps
module ierp_host (
	input wire logic MCLK,
	output logic CS_N,
	output logic OE_N,
	output logic WE_N,
	output logic [4:0] ADDR,
	output logic [7:0] DATA_IN,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE
);
	initial {CS_N, OE_N, WE_N, ADDR, DATA_IN} = '1;
	task acc(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [8:0] r);
		@(posedge MCLK) #2;
		{CS_N, OE_N, WE_N, ADDR, DATA_IN} = {1'h0, w, !w, a, d};
		repeat (4) @(posedge MCLK);
		// Sample once the edge's results have settled, then release
		#2 r = {DATA_OE, DATA_OUT};
		{CS_N, OE_N, WE_N, ADDR, DATA_IN} = {3'h7, ~a, ~d};
		repeat (2) @(posedge MCLK) #2;
	endtask : acc
endmodule : ierp_host

/* File: verif/test_ierp_top.sv */
/* Self-checking bench: host model, byte model, checker.
 * Assumes the checker binds itself. */
`timescale 1ns/1ps
module test_ierp_top;
	logic MCLK = 0, RST_N = 0, CLK_EN = 1, BURST_INCREMENT_ENABLE = 0;
	logic CS_N, OE_N, WE_N, DATA_OE, ACCESS_BUSY;
	logic [4:0] ADDR;
	logic [7:0] DATA_IN, DATA_OUT, p, q = 8'h00, m [256];
	logic [8:0] r;
	int fail_count = 0, n_compared = 0, i;
	ierp_top dut (.MCLK, .RST_N, .CLK_EN, .CS_N, .OE_N, .WE_N, .ADDR, .DATA_IN,
		.BURST_INCREMENT_ENABLE, .DATA_OUT, .DATA_OE, .ACCESS_BUSY);
	ierp_host h (.MCLK, .CS_N, .OE_N, .WE_N, .ADDR, .DATA_IN, .DATA_OUT, .DATA_OE);
	initial forever #12.5 MCLK = !MCLK;
	task wr(input logic [4:0] a, input logic [7:0] d);
		h.acc(1'h1, a, d, r);
		if (a == 5'h10) p = d;
		if (a == 5'h13) begin
			m[p] = d;
			p += BURST_INCREMENT_ENABLE;
		end
	endtask : wr
	task rd(input logic [4:0] a);
		logic [8:0] e;
		e = a == 5'h10 ? {1'h1, p} : a == 5'h13 ? {1'h1, m[p]} : {1'h0, q};
		h.acc(1'h0, a, 8'h00, r);
		n_compared++;
		if (r !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, r, e);
		end
		q = e[7:0];
		if (a == 5'h13) p += BURST_INCREMENT_ENABLE;
	endtask : rd
	task end_sim;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		#300000;
		fail_count++;
		end_sim;
	end
	initial begin
		void'($urandom(72));
		repeat (4) @(posedge MCLK);
		#2 RST_N = 1;
		BURST_INCREMENT_ENABLE = 1;
		wr(5'h10, 8'hFC);
		for (i = 0; i < 8; i++) wr(5'h13, 8'($urandom));
		wr(5'h10, 8'hFC);
		for (i = 0; i < 8; i++) rd(5'h13);
		rd(5'h10);
		$display("test 1 done");
		BURST_INCREMENT_ENABLE = 0;
		wr(5'h10, 8'($urandom));
		repeat (2) wr(5'h13, 8'($urandom));
		repeat (2) rd(5'h13);
		rd(5'h10);
		$display("test 2 done");
		wr(5'h11, 8'hA5);
		rd(5'h11);
		@(posedge MCLK) #2 CLK_EN = 0;
		h.acc(1'h1, 5'h10, ~p, r);
		CLK_EN = 1;
		rd(5'h10);
		@(posedge MCLK) #2 RST_N = 0;
		repeat (2) @(posedge MCLK);
		#2 RST_N = 1;
		q = ierp_pkg::DOUT_RST;
		rd(5'h11);
		rd(5'h13);
		$display("test 3 done");
		end_sim;
	end
endmodule : test_ierp_top
